/* include/asa_pkg.sv */
// shared constants, register layouts and state types of the serial adapter
package asa_pkg;
  localparam int SYS_HZ = 10_000_000;
  localparam int OVERSAMPLE = 16;
  localparam int TICKS_BIT = 16;
  localparam int TICKS_HALF = 8;
  localparam int TICKS_STOP_ONE = 16;
  localparam int TICKS_STOP_HALF3 = 24;
  localparam int TICKS_STOP_TWO = 32;
  localparam int DIV_W = 14;
  // rate select 0 means the external 16x clock; the rest are baud figures
  localparam int BAUD_TBL [16] = '{0, 50, 75, 110, 135, 150, 300, 600, 1200, 1800,
                                   2400, 3600, 4800, 7200, 9600, 19200};
  localparam logic [4:0] OFF_DATA = 5'h00;
  localparam logic [4:0] OFF_STATUS = 5'h04;
  localparam logic [4:0] OFF_CMD = 5'h08;
  localparam logic [4:0] OFF_CTRL = 5'h0C;
  localparam logic [4:0] OFF_IRQ_PEND = 5'h10;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h14;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [1:0] WL_FIVE = 2'h3;
  localparam logic [1:0] RTS_OFF = 2'h0;
  localparam int EV_FE = 1;
  localparam int EV_OVRN = 2;
  localparam int EV_RDRF = 3;
  localparam int EV_TDRE = 4;
  localparam int EV_DCD = 5;
  localparam int EV_DSR = 6;

  typedef struct packed {
    logic       two_stop;
    logic [1:0] word_len;
    logic       rx_gen_clk;
    logic [3:0] rate;
  } asa_ctrl_t;

  typedef struct packed {
    logic [2:0] spare;
    logic       echo;
    logic [1:0] rts;
    logic       rx_irq_en;
    logic       term_ready;
  } asa_cmd_t;

  typedef struct packed {
    logic irq;
    logic dsr;
    logic dcd;
    logic tdre;
    logic rdrf;
    logic ovrn;
    logic fe;
    logic pe;
  } asa_status_t;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} asa_state_t;
endpackage : asa_pkg

/* hw/asa_top.sv */
// serial adapter: register slave, baud generator, transmitter and receiver
// Operation
// - tx rate: table of fifteen, or external/16
// - rx clock: tx rate or external/16
// - five to eight data bits, no parity
// - control: stop bits, length, rx source, rate
// - command: echo, request line, rx irq, ready
// - status shows irq, lines, flags, errors
// - data write loads tx shifter directly
// - finished char moves to rx holding
// - unread holding at transfer flags overrun
// - tx and rx run independently, full duplex
// - transfers only while selected, one phase
// - data offset: write tx, read rx
// - lsb first, unused rx bits zero
// - enabled events pull interrupt low, set bit7
`timescale 1ns/100ps
module asa_top (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        serial_in,
  input  wire logic        rx_clk_in,
  input  wire logic        set_ready_in_n,
  input  wire logic        carrier_detect_in_n,
  output logic             serial_out,
  output logic             request_send_n,
  output logic             terminal_ready_n,
  output logic             irq_out_n
);

  function automatic logic [asa_pkg::DIV_W-1:0] baud_div(input logic [3:0] rate);
    int d;
    d = 1;
    if (rate != 4'h0) begin
      d = asa_pkg::SYS_HZ / (asa_pkg::OVERSAMPLE * asa_pkg::BAUD_TBL[rate]);
    end
    return d[asa_pkg::DIV_W-1:0];
  endfunction : baud_div

  function automatic logic [2:0] last_bit(input logic [1:0] word_len);
    return 3'h7 - {1'b0, word_len};
  endfunction : last_bit

  asa_pkg::asa_ctrl_t ctrl;
  asa_pkg::asa_cmd_t  cmd;
  logic [7:0]  irq_mask;
  logic [7:0]  irq_pend;
  logic        bus_ack;
  logic        req;
  logic        wr_take;
  logic        rd_take;
  logic        wr_data;
  logic        rd_data;
  logic        irq_any;

  // bus: one wait state on every access, then the access is taken; a write only with byte enable 0 set
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~bus_ack;
  assign wr_take = avs_write & bus_ack & avs_byteenable[0];
  assign rd_take = avs_read & bus_ack;
  assign wr_data = wr_take && avs_address == asa_pkg::OFF_DATA;
  assign rd_data = rd_take && avs_address == asa_pkg::OFF_DATA;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= req & ~bus_ack;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl     <= asa_pkg::CTRL_RST;
      cmd      <= asa_pkg::CMD_RST;
      irq_mask <= asa_pkg::MASK_RST;
    end else if (wr_take) begin
      case (avs_address)
        asa_pkg::OFF_CTRL:     ctrl <= avs_writedata[7:0];
        asa_pkg::OFF_CMD:      cmd <= avs_writedata[7:0];
        asa_pkg::OFF_IRQ_MASK: irq_mask <= avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  // baud generator: divider tick or rising edge of the external clock
  logic                     ext_q;
  logic                     ext_tick;
  logic [asa_pkg::DIV_W-1:0] div_cnt;
  logic                     div_tick;
  logic                     tx_tick;
  logic                     rx_tick;

  assign ext_tick = rx_clk_in & ~ext_q;
  assign div_tick = div_cnt >= baud_div(ctrl.rate) - 1'b1;
  assign tx_tick = (ctrl.rate == 4'h0) ? ext_tick : div_tick;
  assign rx_tick = ctrl.rx_gen_clk ? tx_tick : ext_tick;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ext_q   <= 1'b0;
      div_cnt <= '0;
    end else begin
      ext_q   <= rx_clk_in;
      div_cnt <= div_tick ? '0 : div_cnt + 1'b1;
    end
  end

  // transmitter: no holding stage, a write restarts the frame
  asa_pkg::asa_state_t tx_st;
  logic [7:0]          tx_shifter;
  logic [5:0]          tx_cnt;
  logic [5:0]          tx_limit;
  logic [2:0]          tx_bit;
  logic                tx_done;
  logic                next_line;

  always_comb begin
    tx_limit = 6'(asa_pkg::TICKS_BIT);
    if (tx_st == asa_pkg::ST_STOP) begin
      if (!ctrl.two_stop) begin
        tx_limit = 6'(asa_pkg::TICKS_STOP_ONE);
      end else if (ctrl.word_len == asa_pkg::WL_FIVE) begin
        tx_limit = 6'(asa_pkg::TICKS_STOP_HALF3);
      end else begin
        tx_limit = 6'(asa_pkg::TICKS_STOP_TWO);
      end
    end
  end

  assign tx_done = tx_st == asa_pkg::ST_STOP && tx_tick && tx_cnt == tx_limit - 1'b1;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_st      <= asa_pkg::ST_IDLE;
      tx_shifter <= 8'h00;
      tx_cnt     <= '0;
      tx_bit     <= '0;
    end else if (wr_data) begin
      tx_shifter <= avs_writedata[7:0];
      tx_st      <= asa_pkg::ST_START;
      tx_cnt     <= '0;
      tx_bit     <= '0;
    end else if (tx_st != asa_pkg::ST_IDLE && tx_tick) begin
      tx_cnt <= tx_cnt + 1'b1;
      if (tx_cnt == tx_limit - 1'b1) begin
        tx_cnt <= '0;
        case (tx_st)
          asa_pkg::ST_START: tx_st <= asa_pkg::ST_DATA;
          asa_pkg::ST_DATA: begin
            tx_shifter <= tx_shifter >> 1;
            tx_bit     <= tx_bit + 1'b1;
            if (tx_bit == last_bit(ctrl.word_len)) begin
              tx_st <= asa_pkg::ST_STOP;
            end
          end
          default: tx_st <= asa_pkg::ST_IDLE;
        endcase
      end
    end
  end

  always_comb begin
    case (tx_st)
      asa_pkg::ST_START: next_line = 1'b0;
      asa_pkg::ST_DATA:  next_line = tx_shifter[0];
      default:           next_line = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      serial_out <= 1'b1;
    end else begin
      serial_out <= cmd.echo ? serial_in : next_line;
    end
  end

  // receiver: runs apart from the transmitter on its own tick
  asa_pkg::asa_state_t rx_st;
  logic [7:0]          rx_shifter;
  logic [7:0]          rx_holding_reg;
  logic [4:0]          rx_cnt;
  logic [2:0]          rx_bit;
  logic                rx_xfer;

  assign rx_xfer = rx_st == asa_pkg::ST_STOP && rx_tick
                   && rx_cnt == 5'(asa_pkg::TICKS_BIT - 1);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_st      <= asa_pkg::ST_IDLE;
      rx_shifter <= 8'h00;
      rx_cnt     <= '0;
      rx_bit     <= '0;
    end else if (rx_tick) begin
      rx_cnt <= rx_cnt + 1'b1;
      case (rx_st)
        asa_pkg::ST_IDLE: begin
          rx_cnt <= {4'h0, serial_in}; // a start needs a high tick first
          if (!serial_in && rx_cnt[0]) begin
            rx_st <= asa_pkg::ST_START;
          end
        end
        asa_pkg::ST_START: begin
          if (rx_cnt == 5'(asa_pkg::TICKS_HALF - 1)) begin
            rx_cnt     <= '0;
            rx_bit     <= '0;
            rx_shifter <= 8'h00;
            rx_st      <= serial_in ? asa_pkg::ST_IDLE : asa_pkg::ST_DATA;
          end
        end
        asa_pkg::ST_DATA: begin
          if (rx_cnt == 5'(asa_pkg::TICKS_BIT - 1)) begin
            rx_cnt             <= '0;
            rx_shifter[rx_bit] <= serial_in;
            rx_bit             <= rx_bit + 1'b1;
            if (rx_bit == last_bit(ctrl.word_len)) begin
              rx_st <= asa_pkg::ST_STOP;
            end
          end
        end
        default: begin
          if (rx_xfer) begin
            rx_st <= asa_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // status flags: a transfer in the same cycle as a data read wins
  logic rdrf;
  logic ovrn;
  logic fe;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_holding_reg <= 8'h00;
      rdrf           <= 1'b0;
      ovrn           <= 1'b0;
      fe             <= 1'b0;
    end else if (rx_xfer) begin
      rx_holding_reg <= rx_shifter;
      rdrf           <= 1'b1;
      ovrn           <= rdrf & ~rd_data | ovrn;
      fe             <= ~serial_in;
    end else if (rd_data) begin
      rdrf <= 1'b0;
      ovrn <= 1'b0;
      fe   <= 1'b0;
    end
  end

  // sticky events, cleared by writing one, gated by the mask
  logic       dsr_q;
  logic       dcd_q;
  logic [7:0] ev;
  logic [7:0] pend_clr;

  always_comb begin
    ev = 8'h00;
    ev[asa_pkg::EV_FE]   = rx_xfer & ~serial_in;
    ev[asa_pkg::EV_OVRN] = rx_xfer & rdrf & ~rd_data;
    ev[asa_pkg::EV_RDRF] = rx_xfer & cmd.rx_irq_en;
    ev[asa_pkg::EV_TDRE] = tx_done;
    ev[asa_pkg::EV_DCD]  = carrier_detect_in_n ^ dcd_q;
    ev[asa_pkg::EV_DSR]  = set_ready_in_n ^ dsr_q;
  end

  assign pend_clr = (wr_take && avs_address == asa_pkg::OFF_IRQ_PEND)
                    ? avs_writedata[7:0] : 8'h00;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_pend <= 8'h00;
      dsr_q    <= 1'b1;
      dcd_q    <= 1'b1;
    end else begin
      irq_pend <= (irq_pend & ~pend_clr) | ev;
      dsr_q    <= set_ready_in_n;
      dcd_q    <= carrier_detect_in_n;
    end
  end

  assign irq_any = |(irq_pend & irq_mask);
  assign irq_out_n = ~irq_any;
  assign request_send_n = cmd.rts == asa_pkg::RTS_OFF;
  assign terminal_ready_n = ~cmd.term_ready;

  asa_pkg::asa_status_t status;

  always_comb begin
    status.irq  = irq_any;
    status.dsr  = set_ready_in_n;
    status.dcd  = carrier_detect_in_n;
    status.tdre = tx_st == asa_pkg::ST_IDLE;
    status.rdrf = rdrf;
    status.ovrn = ovrn;
    status.fe   = fe;
    status.pe   = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !bus_ack) begin
      avs_readdata <= 32'h0000_0000;
      case (avs_address)
        asa_pkg::OFF_DATA:     avs_readdata[7:0] <= rx_holding_reg;
        asa_pkg::OFF_STATUS:   avs_readdata[7:0] <= status;
        asa_pkg::OFF_CMD:      avs_readdata[7:0] <= cmd;
        asa_pkg::OFF_CTRL:     avs_readdata[7:0] <= ctrl;
        asa_pkg::OFF_IRQ_PEND: avs_readdata[7:0] <= irq_pend;
        asa_pkg::OFF_IRQ_MASK: avs_readdata[7:0] <= irq_mask;
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_new_req;
    req && !bus_ack;
  endsequence

  sequence s_char_in;
    rx_xfer;
  endsequence

  a_bus_one_wait: assert property (s_new_req |-> avs_waitrequest ##1 (!avs_waitrequest || !req))
    else $error("access not answered after one wait state");
  a_rd_data_sel: assert property ((s_new_req and avs_read && avs_address == asa_pkg::OFF_DATA)
      |=> avs_readdata[7:0] == $past(rx_holding_reg))
    else $error("data read does not return the rx holding byte");
  a_tx_load: assert property (wr_data |=> tx_st == asa_pkg::ST_START
      && tx_shifter == $past(avs_writedata[7:0]))
    else $error("data write did not load the tx shifter");
  a_tx_start_low: assert property ((tx_st == asa_pkg::ST_START && !cmd.echo) |=> !serial_out)
    else $error("start bit not low");
  a_tx_idle_high: assert property ((tx_st == asa_pkg::ST_IDLE && !cmd.echo) |=> serial_out)
    else $error("idle line not high");
  a_rx_full_set: assert property (s_char_in |=> rdrf && rx_holding_reg == $past(rx_shifter))
    else $error("received char not moved to holding");
  a_rx_overrun: assert property ((s_char_in and rdrf && !rd_data)
      |=> ovrn ##1 (ovrn || $past(rd_data)))
    else $error("overrun not flagged");
  a_frame_err: assert property ((s_char_in and !serial_in) |=> fe)
    else $error("framing error not flagged");
  a_rx_high_zero: assert property ((s_char_in and ctrl.word_len == asa_pkg::WL_FIVE)
      |=> rx_holding_reg[7:5] == 3'h0)
    else $error("unused rx bits not zero");
  a_irq_on_char: assert property ((s_char_in and cmd.rx_irq_en && irq_mask[asa_pkg::EV_RDRF])
      |=> !irq_out_n && status.irq)
    else $error("enabled rx event did not raise interrupt");
  a_rts_level: assert property ((wr_take && avs_address == asa_pkg::OFF_CMD)
      |=> request_send_n == ($past(avs_writedata[3:2]) == asa_pkg::RTS_OFF))
    else $error("request line does not follow command");

endmodule : asa_top

/* test/asa_modem_model.sv */
// far-end modem model: baud reference, character sender, frame decoder
`timescale 1ns/100ps
module asa_modem_model #(
  parameter int BIT_CYC = 64
) (
  input  wire logic sys_clk,
  input  wire logic serial_out,
  output logic      serial_in,
  output logic      rx_clk_in
);
  int         nbits = 8;
  int         bit_cyc = BIT_CYC;
  int         got_cnt = 0;
  logic [7:0] got;
  logic       got_stop;
  logic [1:0] div = 2'h0;

  initial begin
    serial_in = 1'b1;
    rx_clk_in = 1'b0;
  end

  // free-running 16x baud reference, one tick every four system clocks
  always @(posedge sys_clk) begin
    div       <= div + 2'h1;
    rx_clk_in <= div[1];
  end

  task automatic send_char(input logic [7:0] b, input int n, input logic stop);
    serial_in <= 1'b0;
    repeat (bit_cyc) @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      serial_in <= b[i];
      repeat (bit_cyc) @(posedge sys_clk);
    end
    serial_in <= stop;
    repeat (bit_cyc) @(posedge sys_clk);
    serial_in <= 1'b1;
    repeat (bit_cyc) @(posedge sys_clk);
  endtask : send_char

  // samples each bit in its middle, timed from the falling start edge
  initial forever begin
    @(negedge serial_out);
    got = 8'h00;
    repeat (bit_cyc / 2) @(posedge sys_clk);
    for (int i = 0; i < nbits; i++) begin
      repeat (bit_cyc) @(posedge sys_clk);
      got[i] = serial_out;
    end
    repeat (bit_cyc) @(posedge sys_clk);
    got_stop = serial_out;
    got_cnt++;
  end
endmodule : asa_modem_model

/* test/tb_top.sv */
// self-checking bench of the serial adapter over its register bus
`timescale 1ns/100ps
module tb_top;
  logic        sys_clk;
  logic        resetn;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        serial_in;
  logic        rx_clk_in;
  logic        set_ready_in_n;
  logic        carrier_detect_in_n;
  logic        serial_out;
  logic        request_send_n;
  logic        terminal_ready_n;
  logic        irq_out_n;
  int          err_count = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          c;
  logic [7:0]  d;

  asa_top dut (
    .sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .serial_in(serial_in),
    .rx_clk_in(rx_clk_in), .set_ready_in_n(set_ready_in_n),
    .carrier_detect_in_n(carrier_detect_in_n), .serial_out(serial_out),
    .request_send_n(request_send_n), .terminal_ready_n(terminal_ready_n),
    .irq_out_n(irq_out_n)
  );

  asa_modem_model #(.BIT_CYC(64)) pm (
    .sys_clk(sys_clk), .serial_out(serial_out), .serial_in(serial_in), .rx_clk_in(rx_clk_in)
  );

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish();
    if (err_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      $display("Error at %0t: run did not finish", $time);
      tally_and_finish();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic av(input logic [4:0] a, input logic w, input logic [7:0] wd,
                    output logic [7:0] rd_v);
    avs_address   <= a;
    avs_read      <= ~w;
    avs_write     <= w;
    avs_writedata <= {24'h000000, wd};
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd_v = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask : av

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    logic [7:0] x;
    av(a, 1'b1, v, x);
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    av(a, 1'b0, 8'h00, v);
  endtask : rd

  task automatic wait_stat(input logic [7:0] m, input logic [7:0] v);
    logic [7:0] s;
    for (int i = 0; i < 300; i++) begin
      rd(asa_pkg::OFF_STATUS, s);
      if ((s & m) === v) break;
    end
    chk(s & m, v);
  endtask : wait_stat

  task automatic wait_frame(input int c0);
    for (int i = 0; i < 6000 && pm.got_cnt == c0; i++) @(posedge sys_clk);
    chk(8'(pm.got_cnt - c0), 8'h01);
  endtask : wait_frame

  task automatic rx_chk(input logic [7:0] b, input int n, input logic [7:0] exp);
    pm.send_char(b, n, 1'b1);
    wait_stat(8'h0F, 8'h08);
    rd(asa_pkg::OFF_DATA, d);
    chk(d, exp);
  endtask : rx_chk

  initial begin
    resetn = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    set_ready_in_n = 1'b1;
    carrier_detect_in_n = 1'b0;
    repeat (8) @(posedge sys_clk);
    chk({serial_out, request_send_n, terminal_ready_n, irq_out_n, 4'h0}, 8'hF0);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rd(asa_pkg::OFF_CTRL, d);
    chk(d, 8'h00);
    rd(asa_pkg::OFF_CMD, d);
    chk(d, 8'h00);
    rd(asa_pkg::OFF_STATUS, d);
    chk(d, 8'h50);
    wr(asa_pkg::OFF_CMD, 8'h05);
    chk({6'h00, request_send_n, terminal_ready_n}, 8'h00);
    wr(asa_pkg::OFF_CMD, 8'h00);
    chk({6'h00, request_send_n, terminal_ready_n}, 8'h03);
    avs_byteenable <= 4'h0;
    wr(asa_pkg::OFF_CTRL, 8'h33);
    avs_byteenable <= 4'hF;
    wr(5'h18, 8'hAA);
    rd(5'h18, d);
    chk(d, 8'h00);
    rd(asa_pkg::OFF_CTRL, d);
    chk(d, 8'h00);
    set_ready_in_n <= 1'b0;
    carrier_detect_in_n <= 1'b1;
    wait_stat(8'h60, 8'h20);
    for (int wl = 0; wl < 4; wl++) begin
      pm.nbits = 8 - wl;
      wr(asa_pkg::OFF_CTRL, {1'b0, wl[1:0], 5'h00});
      c = pm.got_cnt;
      wr(asa_pkg::OFF_DATA, 8'hB6);
      rd(asa_pkg::OFF_STATUS, d);
      chk(d & 8'h10, 8'h00);
      wait_frame(c);
      chk(pm.got, 8'hB6 & (8'hFF >> wl));
      chk({7'h00, pm.got_stop}, 8'h01);
      wait_stat(8'h10, 8'h10);
    end
    pm.nbits = 8;
    wr(asa_pkg::OFF_CTRL, 8'h60);
    rx_chk(8'hFF, 5, 8'h1F);
    wr(asa_pkg::OFF_CTRL, 8'h10);
    rx_chk(8'h5A, 8, 8'h5A);
    pm.bit_cyc = 512;
    wr(asa_pkg::OFF_CTRL, 8'h1F);
    rx_chk(8'hA5, 8, 8'hA5);
    c = pm.got_cnt;
    wr(asa_pkg::OFF_DATA, 8'h3C);
    wait_frame(c);
    chk(pm.got, 8'h3C);
    wait_stat(8'h10, 8'h10);
    pm.bit_cyc = 64;
    wr(asa_pkg::OFF_CTRL, 8'h10);
    fork
      pm.send_char(8'h96, 8, 1'b1);
      begin
        c = pm.got_cnt;
        wr(asa_pkg::OFF_DATA, 8'h69);
        wait_frame(c);
      end
    join
    chk(pm.got, 8'h69);
    rd(asa_pkg::OFF_DATA, d);
    chk(d, 8'h96);
    pm.send_char(8'h11, 8, 1'b1);
    pm.send_char(8'h22, 8, 1'b1);
    wait_stat(8'h0E, 8'h0C);
    rd(asa_pkg::OFF_DATA, d);
    chk(d, 8'h22);
    wait_stat(8'h0E, 8'h00);
    pm.send_char(8'h33, 8, 1'b0);
    wait_stat(8'h02, 8'h02);
    rd(asa_pkg::OFF_DATA, d);
    wait_stat(8'h02, 8'h00);
    wr(asa_pkg::OFF_CMD, 8'h10);
    c = pm.got_cnt;
    pm.send_char(8'hC3, 8, 1'b1);
    wait_frame(c);
    chk(pm.got, 8'hC3);
    rd(asa_pkg::OFF_DATA, d);
    wr(asa_pkg::OFF_IRQ_PEND, 8'hFF);
    chk({7'h00, irq_out_n}, 8'h01);
    wr(asa_pkg::OFF_IRQ_MASK, 8'h08);
    wr(asa_pkg::OFF_CMD, 8'h02);
    pm.send_char(8'h44, 8, 1'b1);
    chk({7'h00, irq_out_n}, 8'h00);
    wait_stat(8'h88, 8'h88);
    wr(asa_pkg::OFF_IRQ_PEND, 8'h08);
    chk({7'h00, irq_out_n}, 8'h01);
    wr(asa_pkg::OFF_IRQ_MASK, 8'h00);
    carrier_detect_in_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk({7'h00, irq_out_n}, 8'h01);
    rd(asa_pkg::OFF_IRQ_PEND, d);
    chk(d & 8'h20, 8'h20);
    wr(asa_pkg::OFF_IRQ_MASK, 8'h20);
    chk({7'h00, irq_out_n}, 8'h00);
    wr(asa_pkg::OFF_IRQ_PEND, 8'h20);
    chk({7'h00, irq_out_n}, 8'h01);
    tally_and_finish();
  end
endmodule : tb_top
